// ### rtl/ctq_pkg.sv
package ctq_pkg;
    // ========================================================
    // widths
    localparam int CTQ_ADDR_W = 12;
    localparam int CTQ_NUM_DI = 6;
    localparam int CTQ_OTHER_W = 16;
    localparam int CTQ_TIME_W = 17;
    localparam int CTQ_CFG_W = 16;
    // ========================================================
    // register byte addresses
    localparam logic [11:0] CTQ_ADDR_CFG = 12'h000;
    localparam logic [11:0] CTQ_ADDR_ENSEL = 12'h004;
    localparam logic [11:0] CTQ_ADDR_STAT = 12'h008;
    // ========================================================
    // timer 1 day/season configuration word
    localparam logic [15:0] CTQ_CFG_RESET = 16'h0780;
    localparam logic [15:0] CTQ_CFG_WMASK = 16'h3FFF;
    localparam int CTQ_WD_LSB = 0;
    localparam int CTQ_WD_N = 7;
    localparam int CTQ_SEASON_LSB = 7;
    localparam int CTQ_SEASON_N = 4;
    localparam int CTQ_EXC_BIT = 11;
    localparam int CTQ_HOL_BIT = 12;
    localparam int CTQ_WORK_BIT = 13;
    // ========================================================
    // enable source select register
    localparam int CTQ_ENSEL_CODE_LSB = 0;
    localparam int CTQ_ENSEL_IDX_LSB = 4;
    localparam logic [7:0] CTQ_ENSEL_RESET = 8'h00;
    localparam logic [3:0] CTQ_SRC_OFF = 4'h0;
    localparam logic [3:0] CTQ_SRC_ON = 4'h1;
    localparam logic [3:0] CTQ_SRC_DI1 = 4'h2;
    localparam logic [3:0] CTQ_SRC_DI6 = 4'h7;
    localparam logic [3:0] CTQ_SRC_OTHER = 4'h8;
    // ========================================================
    // status register bits
    localparam int CTQ_STAT_ACTIVE = 0;
    localparam int CTQ_STAT_ENABLE = 1;
    localparam int CTQ_STAT_WINDOW = 2;
    localparam int CTQ_STAT_DAYQ = 3;
    // ========================================================
    // seconds in one day
    localparam logic [17:0] CTQ_DAY_SECONDS = 18'h15180;
endpackage

// ### rtl/ctq_qual_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ctq_qual_if;
    import ctq_pkg::*;
    logic [3:0] src_code;
    logic [3:0] other_idx;
    logic [CTQ_NUM_DI-1:0] di_status;
    logic [CTQ_OTHER_W-1:0] other_word;
    logic src_enable;
    logic [CTQ_TIME_W-1:0] cur_time;
    logic [CTQ_TIME_W-1:0] start_time;
    logic [CTQ_TIME_W-1:0] duration;
    logic in_window;
    modport core (
        output src_code, other_idx, di_status, other_word,
        output cur_time, start_time, duration,
        input src_enable, in_window
    );
    modport sel (
        input src_code, other_idx, di_status, other_word,
        output src_enable
    );
    modport win (
        input cur_time, start_time, duration,
        output in_window
    );
endinterface
`default_nettype wire

// ### rtl/ctq_en_sel.sv
`timescale 1ns/1ns
`default_nettype none
module ctq_en_sel (
    // selector side of the shared bundle
    ctq_qual_if.sel q
);
    import ctq_pkg::*;

    logic [CTQ_NUM_DI-1:0] di_hit;

    genvar k;
    generate
        for (k = 0; k < CTQ_NUM_DI; k++) begin : g_di
            assign di_hit[k] = (q.src_code == CTQ_SRC_DI1 + 4'(k))
                && q.di_status[k]; // RQ9
        end
    endgenerate

    // codes above the other-bit choice select nothing and read as off
    always_comb begin
        q.src_enable = (|di_hit)
            || (q.src_code == CTQ_SRC_ON) // RQ11
            || ((q.src_code == CTQ_SRC_OTHER)
                && q.other_word[q.other_idx]); // RQ10
    end
endmodule
`default_nettype wire

// ### rtl/ctq_window.sv
`timescale 1ns/1ns
`default_nettype none
module ctq_window (
    // window side of the shared bundle
    ctq_qual_if.win q
);
    import ctq_pkg::*;

    logic [17:0] end_c;
    logic [17:0] now_c;
    logic [17:0] start_c;

    // a window that runs past midnight continues into the next day
    always_comb begin
        start_c = {1'b0, q.start_time};
        now_c = {1'b0, q.cur_time};
        end_c = start_c + {1'b0, q.duration};
        if (q.duration == '0 || start_c >= CTQ_DAY_SECONDS) begin
            q.in_window = 1'b0;
        end else if (end_c <= CTQ_DAY_SECONDS) begin
            q.in_window = (now_c >= start_c) && (now_c < end_c); // RQ12
        end else begin
            q.in_window = (now_c >= start_c)
                || (now_c < end_c - CTQ_DAY_SECONDS); // RQ12
        end
    end
endmodule
`default_nettype wire

// ### rtl/ctq_top.sv
// How it works
// (RQ1) Config bits 0..6 allow Monday..Sunday as start days; the code checks the current weekday, also past midnight in a window.
// (RQ2) Config bits 7..10 allow seasons one..four; current season bit must be set.
// (RQ3) Exception bit 11 clear: only weekday, season and time window count.
// (RQ4) Bit 11 set: exception days follow bits 12/13; both clear means inactive.
// (RQ5) Holiday bit 12, with bit 11, allows holiday exception days in window.
// (RQ6) Workday bit 13, with bit 11, allows workday exception days in window.
// (RQ7) On exception days weekday and season bits are ignored.
// (RQ8) Configuration word resets to 0x0780: all seasons, no weekdays.
// (RQ9) Enable source may be debounced digital input one..six, bits 0..5; the code only synchronises the pins with two flops.
// (RQ10) Enable source may be any single bit of another status word.
// (RQ11) Enable source may be constant off (0) or on (1); off by default.
// (RQ12) Output needs enable, qualifying day and time inside start..start+dur.
// (RQ13) Config bits 14 and 15 read zero and have no effect.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module ctq_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ctq_pkg::CTQ_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // digital input pins, raw
    input wire logic digital_input_one,
    input wire logic digital_input_two,
    input wire logic digital_input_three,
    input wire logic digital_input_four,
    input wire logic digital_input_five,
    input wire logic digital_input_six,
    // another device status word
    input wire logic [ctq_pkg::CTQ_OTHER_W-1:0] other_status_word,
    // calendar source
    input wire logic [2:0] cur_weekday,
    input wire logic [1:0] cur_season,
    input wire logic exc_day_holiday,
    input wire logic exc_day_workday,
    input wire logic [ctq_pkg::CTQ_TIME_W-1:0] cur_time,
    input wire logic [ctq_pkg::CTQ_TIME_W-1:0] start_time,
    input wire logic [ctq_pkg::CTQ_TIME_W-1:0] duration,
    // result
    output logic timer1_active
);
    import ctq_pkg::*;

    // ========================================================
    // declarations
    logic [CTQ_CFG_W-1:0] cfg_q;
    logic cfg_written_q;
    logic [7:0] ensel_q;
    logic [3:0] stat_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic active_q;
    logic [CTQ_NUM_DI-1:0] di_meta_q;
    logic [CTQ_NUM_DI-1:0] debounced_input_status_word_q;
    logic [CTQ_NUM_DI-1:0] di_pins;
    logic setup_c;
    logic wr_c;
    logic hit_c;
    logic [31:0] rd_c;
    logic [CTQ_WD_N-1:0] wd_bits;
    logic [CTQ_SEASON_N-1:0] season_bits;
    logic weekday_ok;
    logic season_ok;
    logic exc_day;
    logic exc_rule_day;
    logic exc_sel_ok;
    logic day_qual;
    logic active_d;

    ctq_qual_if qif();

    // ========================================================
    // submodules
    ctq_en_sel u_en_sel (
        .q(qif.sel)
    );

    ctq_window u_window (
        .q(qif.win)
    );

    assign qif.src_code = ensel_q[CTQ_ENSEL_CODE_LSB +: 4];
    assign qif.other_idx = ensel_q[CTQ_ENSEL_IDX_LSB +: 4];
    assign qif.di_status = debounced_input_status_word_q;
    assign qif.other_word = other_status_word;
    assign qif.cur_time = cur_time;
    assign qif.start_time = start_time;
    assign qif.duration = duration;

    // ========================================================
    // digital input synchroniser
    assign di_pins = {digital_input_six, digital_input_five,
        digital_input_four, digital_input_three,
        digital_input_two, digital_input_one};

    // pins are asynchronous; only the second stage feeds logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            di_meta_q <= '0;
            debounced_input_status_word_q <= '0;
        end else begin
            di_meta_q <= di_pins;
            debounced_input_status_word_q <= di_meta_q; // RQ9
        end
    end

    // ========================================================
    // apb slave: zero wait states, answer ready in the access phase
    assign setup_c = psel && !penable;
    assign wr_c = psel && penable && pwrite && pready_q;
    assign hit_c = (paddr == CTQ_ADDR_CFG) || (paddr == CTQ_ADDR_ENSEL)
        || (paddr == CTQ_ADDR_STAT);

    always_comb begin
        rd_c = '0;
        case (paddr)
            CTQ_ADDR_CFG: begin
                rd_c[CTQ_CFG_W-1:0] = cfg_q; // RQ13
            end
            CTQ_ADDR_ENSEL: begin
                rd_c[7:0] = ensel_q;
            end
            CTQ_ADDR_STAT: begin
                rd_c[3:0] = stat_q;
            end
            default: begin
                rd_c = '0;
            end
        endcase
    end

    // read data is sampled in the setup cycle, so status may lag one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup_c;
            if (setup_c) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rd_c;
                pslverr_q <= !hit_c;
            end else if (pready_q) begin
                pslverr_q <= 1'b0;
            end
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    // ========================================================
    // configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= CTQ_CFG_RESET; // RQ8
            cfg_written_q <= 1'b0;
        end else if (wr_c && paddr == CTQ_ADDR_CFG && |pstrb[1:0]) begin
            cfg_written_q <= 1'b1;
            if (pstrb[0]) begin
                cfg_q[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                cfg_q[15:8] <= pwdata[15:8] & CTQ_CFG_WMASK[15:8]; // RQ13
            end
        end
    end

    // ========================================================
    // enable source select register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ensel_q <= CTQ_ENSEL_RESET; // RQ11
        end else if (wr_c && paddr == CTQ_ADDR_ENSEL && pstrb[0]) begin
            ensel_q <= pwdata[7:0];
        end
    end

    // ========================================================
    // day qualification
    assign wd_bits = cfg_q[CTQ_WD_LSB +: CTQ_WD_N];
    assign season_bits = cfg_q[CTQ_SEASON_LSB +: CTQ_SEASON_N];

    always_comb begin
        // weekday code 7 is not a day and never qualifies
        weekday_ok = (cur_weekday <= 3'h6) ? wd_bits[cur_weekday] : 1'b0; // RQ1
        season_ok = season_bits[cur_season]; // RQ2
        exc_day = exc_day_holiday || exc_day_workday;
        exc_rule_day = cfg_q[CTQ_EXC_BIT] && exc_day; // RQ3
        exc_sel_ok = (exc_day_holiday && cfg_q[CTQ_HOL_BIT]) // RQ5
            || (exc_day_workday && cfg_q[CTQ_WORK_BIT]); // RQ6
        if (exc_rule_day) begin
            day_qual = exc_sel_ok; // RQ4 RQ7
        end else begin
            day_qual = weekday_ok && season_ok;
        end
        active_d = qif.src_enable && day_qual && qif.in_window; // RQ12
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= 1'b0;
        end else begin
            active_q <= active_d; // RQ12
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
        end else begin
            stat_q[CTQ_STAT_ACTIVE] <= active_d;
            stat_q[CTQ_STAT_ENABLE] <= qif.src_enable;
            stat_q[CTQ_STAT_WINDOW] <= qif.in_window;
            stat_q[CTQ_STAT_DAYQ] <= day_qual;
        end
    end

    assign timer1_active = active_q;

    // ========================================================
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_gate_open;
        qif.src_enable && qif.in_window;
    endsequence

    sequence s_plain_day;
        !(cfg_q[CTQ_EXC_BIT] && (exc_day_holiday || exc_day_workday));
    endsequence

    property p_rq1;
        s_plain_day ##0 (cur_weekday <= 3'h6 && !wd_bits[cur_weekday])
            |=> !timer1_active;
    endproperty
    a_rq1: assert property (p_rq1) // RQ1
        else $error("active on a weekday that is not allowed");

    property p_rq2;
        s_plain_day ##0 !season_bits[cur_season] |=> !timer1_active;
    endproperty
    a_rq2: assert property (p_rq2) // RQ2
        else $error("active in a season that is not allowed");

    property p_rq3;
        (!cfg_q[CTQ_EXC_BIT] && cur_weekday <= 3'h6 && wd_bits[cur_weekday]
            && season_bits[cur_season]) ##0 s_gate_open |=> timer1_active;
    endproperty
    a_rq3: assert property (p_rq3) // RQ3
        else $error("exception day blocked timer with exceptions off");

    property p_rq4;
        (cfg_q[CTQ_EXC_BIT] && !cfg_q[CTQ_HOL_BIT] && !cfg_q[CTQ_WORK_BIT]
            && (exc_day_holiday || exc_day_workday)) |=> !timer1_active;
    endproperty
    a_rq4: assert property (p_rq4) // RQ4
        else $error("active on exception day with no exception selected");

    property p_rq5;
        (cfg_q[CTQ_EXC_BIT] && cfg_q[CTQ_HOL_BIT] && exc_day_holiday)
            ##0 s_gate_open |=> timer1_active;
    endproperty
    a_rq5: assert property (p_rq5) // RQ5
        else $error("holiday exception did not activate timer");

    property p_rq6;
        (cfg_q[CTQ_EXC_BIT] && cfg_q[CTQ_WORK_BIT] && exc_day_workday)
            ##0 s_gate_open |=> timer1_active;
    endproperty
    a_rq6: assert property (p_rq6) // RQ6
        else $error("workday exception did not activate timer");

    property p_rq7;
        (cfg_q[CTQ_EXC_BIT] && exc_day_holiday && !cfg_q[CTQ_HOL_BIT]
            && !exc_day_workday) |=> !timer1_active;
    endproperty
    a_rq7: assert property (p_rq7) // RQ7
        else $error("weekday or season bits used on exception day");

    property p_rq8;
        !cfg_written_q |-> cfg_q == CTQ_CFG_RESET;
    endproperty
    a_rq8: assert property (p_rq8) // RQ8
        else $error("configuration differs from reset value before write");

    property p_rq9;
        (qif.src_code >= CTQ_SRC_DI1 && qif.src_code <= CTQ_SRC_DI6)
            |-> qif.src_enable
                == debounced_input_status_word_q[3'(qif.src_code - 4'h2)];
    endproperty
    a_rq9: assert property (p_rq9) // RQ9
        else $error("digital input enable source mismatch");

    property p_rq10;
        qif.src_code == CTQ_SRC_OTHER
            |-> qif.src_enable == other_status_word[qif.other_idx];
    endproperty
    a_rq10: assert property (p_rq10) // RQ10
        else $error("other status bit enable source mismatch");

    property p_rq11;
        (qif.src_code == CTQ_SRC_OFF || qif.src_code == CTQ_SRC_ON)
            |-> qif.src_enable == qif.src_code[0];
    endproperty
    a_rq11: assert property (p_rq11) // RQ11
        else $error("constant enable source mismatch");

    property p_rq12;
        timer1_active |-> $past(qif.src_enable) && $past(qif.in_window)
            && $past(day_qual);
    endproperty
    a_rq12: assert property (p_rq12) // RQ12
        else $error("timer active without enable, window or day");

    property p_rq13;
        wr_c && paddr == CTQ_ADDR_CFG |=> cfg_q[15:14] == 2'h0;
    endproperty
    a_rq13: assert property (p_rq13) // RQ13
        else $error("reserved configuration bits stored");

    property p_apb_ready;
        setup_c |=> pready ##1 !pready || setup_c;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("apb answer not given in first access cycle");
endmodule
`default_nettype wire

// ### verif/ctq_cal_model.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// calendar source and input pins
module ctq_cal_model
    import ctq_pkg::*;
(
    // clock
    input wire logic pclk,
    // pins and calendar
    output logic [CTQ_NUM_DI-1:0] di,
    output logic [CTQ_OTHER_W-1:0] other,
    output logic [2:0] wd,
    output logic [1:0] season,
    output logic hol,
    output logic work,
    output logic [CTQ_TIME_W-1:0] t,
    output logic [CTQ_TIME_W-1:0] st,
    output logic [CTQ_TIME_W-1:0] dur
);
    initial begin
        di = 6'h00;
        other = 16'h0000;
        wd = 3'h0;
        season = 2'h0;
        hol = 1'b0;
        work = 1'b0;
        t = 17'h00000;
        st = 17'h00000;
        dur = 17'h00000;
    end
    // call just after a rising edge; the whole day changes at once so
    // the qualifier never sees a half-updated calendar
    task automatic apply(input logic [5:0] d, input logic [15:0] o,
        input logic [2:0] w, input logic [1:0] s, input logic h,
        input logic k, input logic [16:0] tt, input logic [16:0] ss,
        input logic [16:0] dd);
        di <= d;
        other <= o;
        wd <= w;
        season <= s;
        hol <= h;
        work <= k;
        t <= tt;
        st <= ss;
        dur <= dd;
    endtask
endmodule
`default_nettype wire

// ### verif/ctq_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ctq_top_tb;
    import ctq_pkg::*;
    // ========================================================
    // clock, bus and pins
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic timer1_active;
    logic [5:0] di;
    logic [15:0] other;
    logic [2:0] wd;
    logic [1:0] season;
    logic hol;
    logic work;
    logic [16:0] t;
    logic [16:0] st;
    logic [16:0] dur;
    int n_mismatch = 0;
    int tests_run = 0;
    int seed = 17;
    logic [15:0] cfg;
    logic [7:0] ensel;
    logic [31:0] rd;
    logic err;
    always #20 pclk = ~pclk;
    ctq_top u_ctq_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr),
        .digital_input_one(di[0]), .digital_input_two(di[1]),
        .digital_input_three(di[2]), .digital_input_four(di[3]),
        .digital_input_five(di[4]), .digital_input_six(di[5]),
        .other_status_word(other), .cur_weekday(wd),
        .cur_season(season), .exc_day_holiday(hol),
        .exc_day_workday(work), .cur_time(t), .start_time(st),
        .duration(dur), .timer1_active(timer1_active));
    ctq_cal_model u_ctq_cal_model (.pclk(pclk), .di(di), .other(other),
        .wd(wd), .season(season), .hol(hol), .work(work), .t(t),
        .st(st), .dur(dur));
    // ========================================================
    // checking and bus tasks
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task final_report;
        if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // the request stands until pready is seen high at a rising edge;
    // the idle edge at the end keeps two calls from clashing on psel
    task automatic apb(input logic [11:0] a, input logic w,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic set_regs(input logic [15:0] c, input logic [7:0] s);
        cfg = c;
        ensel = s;
        apb(CTQ_ADDR_CFG, 1'b1, {16'h0000, c});
        apb(CTQ_ADDR_ENSEL, 1'b1, {24'h000000, s});
    endtask
    // ========================================================
    // expectations
    function automatic logic in_win(input int tt, input int ss,
        input int dd);
        if (dd == 0 || ss >= 86400)
            return 1'b0;
        if (tt >= ss && tt < ss + dd)
            return 1'b1;
        return (ss + dd > 86400) && (tt < ss + dd - 86400);
    endfunction
    function automatic logic exp_en();
        if (ensel[3:0] == CTQ_SRC_ON)
            return 1'b1;
        if (ensel[3:0] == CTQ_SRC_OTHER)
            return other[ensel[7:4]];
        if (ensel[3:0] >= CTQ_SRC_DI1 && ensel[3:0] <= CTQ_SRC_DI6)
            return di[ensel[3:0] - CTQ_SRC_DI1];
        return 1'b0;
    endfunction
    function automatic logic exp_act();
        logic dq;
        if (cfg[11] && (hol || work))
            dq = (hol && cfg[12]) || (work && cfg[13]);
        else
            dq = (wd != 3'h7) && cfg[wd] && cfg[7 + int'(season)];
        return exp_en() && dq && in_win(int'(t), int'(st), int'(dur));
    endfunction
    task automatic probe(input logic [5:0] d, input logic [15:0] o,
        input logic [2:0] w, input logic [1:0] s, input logic h,
        input logic k, input logic [16:0] tt, input logic [16:0] ss,
        input logic [16:0] dd);
        u_ctq_cal_model.apply(d, o, w, s, h, k, tt, ss, dd);
        repeat (5) @(posedge pclk);
        chk("timer1_active", {31'h0, exp_act()}, {31'h0, timer1_active});
        apb(CTQ_ADDR_STAT, 1'b0, 32'h0);
        chk("enable source", {31'h0, exp_en()}, {31'h0, rd[1]});
        chk("status active", {31'h0, exp_act()},
            {31'h0, rd[0]});
        chk("status window", {31'h0, in_win(t, st, dur)},
            {31'h0, rd[2]});
    endtask
    // ========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("active after reset", 32'h0, {31'h0, timer1_active});
        apb(CTQ_ADDR_CFG, 1'b0, 32'h0);
        chk("cfg reset", 32'h00000780, rd);
        apb(CTQ_ADDR_ENSEL, 1'b0, 32'h0);
        chk("ensel reset", 32'h0, rd);
        apb(12'h00C, 1'b0, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb(CTQ_ADDR_CFG, 1'b1, 32'hFFFFFFFF);
        apb(CTQ_ADDR_CFG, 1'b0, 32'h0);
        chk("cfg reserved", 32'h00003FFF, rd);
        for (int i = 0; i < 7; i++) begin
            for (int j = 0; j < 4; j++) begin
                set_regs((16'h0001 << i) | (16'h0080 << j), 8'h01);
                probe(6'h00, 16'h0, 3'(i), 2'(j), 1'b0, 1'b0, 17'd100, 17'd50, 17'd100);
                probe(6'h00, 16'h0, 3'(i + 1), 2'(j), 1'b0, 1'b0, 17'd100, 17'd50, 17'd100);
                probe(6'h00, 16'h0, 3'(i), 2'(j + 1), 1'b0, 1'b0, 17'd100, 17'd50, 17'd100);
            end
        end
        for (int k = 0; k < 64; k++) begin
            set_regs({2'b00, 3'(k), k[5] ? 11'h7FF : 11'h000}, 8'h01);
            probe(6'h00, 16'h0, 3'h2, 2'h1, k[3], k[4], 17'd70, 17'd60, 17'd20);
        end
        set_regs(16'h07FF, 8'h01);
        probe(6'h00, 16'h0, 3'h0, 2'h0, 1'b0, 1'b0, 17'd59, 17'd60, 17'd20);
        probe(6'h00, 16'h0, 3'h0, 2'h0, 1'b0, 1'b0, 17'd80, 17'd60, 17'd20);
        probe(6'h00, 16'h0, 3'h0, 2'h0, 1'b0, 1'b0, 17'd0, 17'd86399, 17'd2);
        probe(6'h00, 16'h0, 3'h0, 2'h0, 1'b0, 1'b0, 17'd1, 17'd86399, 17'd2);
        probe(6'h00, 16'h0, 3'h0, 2'h0, 1'b0, 1'b0, 17'd5, 17'd5, 17'd0);
        for (int c = 0; c < 16; c++) begin
            set_regs(16'h07FF, 8'($random(seed)) & 8'hF0 | 8'(c));
            probe(6'($random(seed)), 16'($random(seed)), 3'h3, 2'h2, 1'b0, 1'b0, 17'd10, 17'd0, 17'd100);
        end
        for (int r = 0; r < 150; r++) begin
            set_regs(16'($random(seed)), 8'($random(seed)) % 8'h99);
            probe(6'($random(seed)), 16'($random(seed)), 3'($random(seed)), 2'($random(seed)), 1'($random(seed)), 1'($random(seed)), 17'($unsigned($random(seed)) % 86400), 17'($unsigned($random(seed)) % 86400), 17'($unsigned($random(seed)) % 86400));
        end
        final_report;
    end
    initial begin
        repeat (40000) @(posedge pclk);
        n_mismatch++;
        final_report;
    end
endmodule
`default_nettype wire
